/* sim/bad_decoder_chk.sv */
/* Port checker for bad_decoder, bound to every instance.
   Assumes one clock domain and the active-low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module bad_decoder_chk #(
    parameter int NV_ADDR_W = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Streams
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_byte,
    input wire logic rsp_ready,
    input wire logic [5:0] rsp_count,
    input wire logic rsp_overflow,
    input wire logic [3:0] setting_strobe,
    // Memory port
    input wire logic nv_req,
    input wire logic nv_we,
    input wire logic [NV_ADDR_W-1:0] nv_addr,
    input wire logic nv_done,
    input wire logic [7:0] nv_rdata
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_nv_finish;
        nv_req && nv_done;
    endsequence

    sequence s_nv_pending;
        nv_req && !nv_done;
    endsequence

    AST_NV_READ: assert property (s_nv_finish ##0 !nv_we |=> rsp_valid && rsp_byte == $past(nv_rdata))
        else $error("memory byte not replied");
    AST_NV_HOLD: assert property (s_nv_pending |=> nv_req && $stable({nv_we, nv_addr}))
        else $error("memory request changed while pending");
    AST_NV_DROP: assert property (s_nv_finish |=> !nv_req)
        else $error("memory request not dropped");
    AST_WR_SILENT: assert property (s_nv_finish ##0 nv_we |=> !rsp_valid)
        else $error("memory write produced a reply");
    AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte))
        else $error("reply byte not held");
    AST_OVF: assert property (rsp_count > 6'h1a |-> ##[0:1] rsp_overflow)
        else $error("oversized reply not flagged");
    AST_STROBE: assert property (|setting_strobe |-> $onehot(setting_strobe) ##1 setting_strobe == 4'h0)
        else $error("setting strobe malformed");
    AST_BUSY: assert property (rsp_valid |-> !cmd_ready)
        else $error("command taken during reply");
endmodule : bad_decoder_chk

bind bad_decoder bad_decoder_chk #(.NV_ADDR_W(NV_ADDR_W)) chk_u (
    .clock(clock), .rst_n(rst_n), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
    .rsp_ready(rsp_ready), .rsp_count(rsp_count), .rsp_overflow(rsp_overflow), .setting_strobe(setting_strobe),
    .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr), .nv_done(nv_done), .nv_rdata(nv_rdata)
);
`default_nettype wire

/* sim/bad_nv_model.sv */
/* Behavioural byte memory on the decoder's memory port.
   Answer delay comes from the bench; read data is junk outside done. */
`timescale 1ns/1ps
`default_nettype none
module bad_nv_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Memory port
    input wire logic nv_req,
    input wire logic nv_we,
    input wire logic [7:0] nv_addr,
    input wire logic [7:0] nv_wdata,
    output logic nv_done,
    output logic [7:0] nv_rdata,
    // Answer delay in cycles
    input wire logic [3:0] latency
);
    logic [7:0] mem [256];
    logic [3:0] wait_cnt;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nv_done <= 1'b0;
            nv_rdata <= 8'h00;
            wait_cnt <= 4'h0;
        end else begin
            nv_done <= 1'b0;
            nv_rdata <= ~nv_rdata;
            if (nv_req && !nv_done) begin
                wait_cnt <= wait_cnt + 4'h1;
                if (wait_cnt >= latency) begin
                    nv_done <= 1'b1;
                    wait_cnt <= 4'h0;
                    if (nv_we) begin
                        mem[nv_addr] <= nv_wdata;
                    end else begin
                        nv_rdata <= mem[nv_addr];
                    end
                end
            end
        end
    end
endmodule : bad_nv_model
`default_nettype wire

/* sim/test_bad_decoder.sv */
/* Self-checking bench for bad_decoder with the memory model.
   Assumes bad_pkg, bad_decoder, its checker and bad_nv_model compiled. */
`timescale 1ns/1ps
`default_nettype none
module test_bad_decoder;
    logic clock = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_first = 1'b0, rsp_ready = 1'b0;
    logic [7:0] cmd_byte = 8'h00;
    logic [3:0] latency = 4'h0;
    bad_pkg::bad_result_t [3:0] conv_result = '0;
    logic [3:0][7:0] sample_number = '0;
    logic cmd_ready, rsp_valid, rsp_overflow, cmd_error, nv_req, nv_we, nv_done;
    logic [7:0] rsp_byte, nv_addr, nv_wdata, nv_rdata;
    logic [5:0] rsp_count;
    logic [3:0] setting_strobe;
    logic [1:0] e0, e1, e2, e3;
    bad_pkg::bad_setting_t [3:0] channel_setting;
    int err_total = 0, samples_checked = 0;

    always #12.5 clock = ~clock;
    // Random consumer stalls
    always @(posedge clock) #2 rsp_ready = ($urandom % 4) != 0;

    bad_decoder dut_u (
        .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_first(cmd_first),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_ready(rsp_ready),
        .rsp_count(rsp_count), .rsp_overflow(rsp_overflow), .cmd_error(cmd_error), .conv_result(conv_result),
        .sample_number(sample_number), .channel_setting(channel_setting), .setting_strobe(setting_strobe),
        .excitation_field_ch0(e0), .excitation_field_ch1(e1), .excitation_field_ch2(e2),
        .excitation_field_ch3(e3), .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr),
        .nv_wdata(nv_wdata), .nv_done(nv_done), .nv_rdata(nv_rdata)
    );
    bad_nv_model mem_u (
        .clock(clock), .rst_n(rst_n), .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr),
        .nv_wdata(nv_wdata), .nv_done(nv_done), .nv_rdata(nv_rdata), .latency(latency)
    );

    task automatic complete_run();
        $display("checks %0d, errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Offer one byte, hold until taken
    task automatic send(input logic [7:0] b, input logic f);
        logic ok;
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd_byte = b;
        cmd_first = f;
        do begin
            @(negedge clock);
            ok = cmd_ready;
            @(posedge clock);
            n++;
        end while (!ok && n < 200);
        if (!ok) err_total++;
        #2;
    endtask : send

    task automatic recv(output logic [7:0] b);
        logic ok;
        int n;
        n = 0;
        do begin
            @(negedge clock);
            ok = rsp_valid && rsp_ready;
            b = rsp_byte;
            @(posedge clock);
            n++;
        end while (!ok && n < 200);
        if (!ok) err_total++;
        #2;
    endtask : recv

    task automatic idle();
        cmd_valid = 1'b0;
        @(posedge clock);
        #2;
    endtask : idle

    function automatic logic [31:0] exp_word(input bad_pkg::bad_result_t r);
        logic [31:0] w;
        w = {3'b000, r.magnitude};
        w[29] = r.sign_flag;
        if (r.overrange) w[29:28] = 2'b11;
        if (r.underrange) w[29:28] = 2'b00;
        return w;
    endfunction : exp_word

    task automatic read_all(input logic f);
        logic [7:0] b;
        logic [31:0] w;
        send(bad_pkg::OP_READ_ALL, f);
        cmd_valid = 1'b0;
        for (int c = 0; c < 4; c++) begin
            w = exp_word(conv_result[c]);
            for (int k = 0; k < 4; k++) begin
                recv(b);
                check(b, w[8*k +: 8]);
            end
        end
        for (int c = 0; c < 4; c++) begin
            recv(b);
            check(b, sample_number[c]);
        end
    endtask : read_all

    initial begin
        logic [31:0] w;
        logic [11:0] code;
        logic [7:0] v, a, d, b;
        int ch;
        void'($urandom(32'h9fd0));
        repeat (10) @(posedge clock);
        #2;
        rst_n = 1'b1;
        check({e3, e2, e1, e0}, 8'h00);
        for (int i = 0; i < 10; i++) begin
            ch = $urandom % 4;
            code = (i < 9) ? 12'ha01 + 12'(i) : 12'ha0f;
            w = {code, 1'($urandom), 19'h0};
            v = (i == 0) ? 8'hff : (i == 1) ? 8'h1b : 8'($urandom);
            send(bad_pkg::OP_PROGRAM_SETTING, 1'b1);
            send({6'h00, 2'(ch)}, 1'b0);
            for (int k = 0; k < 4; k++) send(w[8*k +: 8], 1'b0);
            send(bad_pkg::OP_EXCITATION, 1'b0);
            send(v, 1'b0);
            idle();
            check(channel_setting[ch], {code, ((i < 9) ? 4'(6 + i) : 4'hf), w[19]});
            check({e3, e2, e1, e0}, v);
            check(rsp_count, 6'h00);
        end
        for (int i = 0; i < 4; i++) begin
            for (int c = 0; c < 4; c++) begin
                conv_result[c] = bad_pkg::bad_result_t'({2'b00, 30'($urandom)});
                sample_number[c] = 8'($urandom);
            end
            conv_result[i].overrange = 1'b1;
            conv_result[(i + 1) % 4].underrange = 1'b1;
            read_all(1'b1);
            check(rsp_count, 6'h14);
            check({e3, e2, e1, e0}, v);
        end
        read_all(1'b1);
        read_all(1'b0);
        check(rsp_overflow, 1'b1);
        for (int i = 0; i < 5; i++) begin
            latency = (i == 0) ? 4'h0 : 4'($urandom % 10);
            a = 8'($urandom);
            d = 8'($urandom);
            send(bad_pkg::OP_NV_WRITE, 1'b1);
            check(rsp_overflow, 1'b0);
            send(a, 1'b0);
            send(d, 1'b0);
            idle();
            send(bad_pkg::OP_NV_READ, 1'b1);
            send(a, 1'b0);
            cmd_valid = 1'b0;
            recv(b);
            check(b, d);
            check(rsp_count, 6'h01);
        end
        // Unknown action skipped until next packet
        send(8'h07, 1'b1);
        check(cmd_error, 1'b1);
        send(8'h55, 1'b0);
        send(bad_pkg::OP_EXCITATION, 1'b1);
        send(8'he4, 1'b0);
        idle();
        check(cmd_error, 1'b0);
        check({e3, e2, e1, e0}, 8'he4);
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #2;
        check({e3, e2, e1, e0}, 8'h00);
        rst_n = 1'b1;
        send(bad_pkg::OP_EXCITATION, 1'b1);
        send(8'h1b, 1'b0);
        idle();
        check({e3, e2, e1, e0}, 8'h1b);
        complete_run();
    end

    initial begin
        #1000000;
        err_total++;
        complete_run();
    end
endmodule : test_bad_decoder
`default_nettype wire

/* src/bad_decoder.sv */
/*
 * Action decoder for a four-channel bridge-sensor input module.
 * Command bytes arrive one per valid/ready beat, opcode first; reply bytes
 * leave one per beat. Converter results, sample numbers and the
 * non-volatile memory live outside and are reached by plain ports.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Opcode 00 programs one channel setting
// - Opcode 01 returns all four results
// - Opcode 02 sets all excitation levels
// - Opcode 0D reads one memory byte
// - Opcode 0E writes one memory byte
// - Response packet at most 26 bytes; longer replies are still sent, with rsp_overflow set
// - Bits 31:20 hold oversample ratio code
// - Bit 19 selects speed multiplier mode
// - Reply: four result words, LSB first
// - Then four sample numbers, 20 bytes
// - Result bits 31 and 30 zero
// - Bit 29 set for positive input
// - Bits 28:0 carry magnitude
// - Overrange sets bits 29 and 28
// - Underrange clears bits 29 and 28; here overrange wins, so both bits stay set when both flags are set
// - Four 2-bit excitation fields, 00=1.25V
// - Excitation held until next excitation command
// - Reset returns excitation to 1.25V
// - Memory read answers one byte
// - Memory write stores data byte
module bad_decoder #(
    parameter int CHANNELS = 4,
    parameter int NV_ADDR_W = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Command byte stream
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_first,
    output logic cmd_ready,
    // Response byte stream
    output logic rsp_valid,
    output logic [7:0] rsp_byte,
    input wire logic rsp_ready,
    output logic [5:0] rsp_count,
    output logic rsp_overflow,
    output logic cmd_error,
    // Converter results and sample numbers
    input wire bad_pkg::bad_result_t [3:0] conv_result,
    input wire logic [3:0][7:0] sample_number,
    // Channel settings
    output bad_pkg::bad_setting_t [3:0] channel_setting,
    output logic [3:0] setting_strobe,
    output logic [1:0] excitation_field_ch0,
    output logic [1:0] excitation_field_ch1,
    output logic [1:0] excitation_field_ch2,
    output logic [1:0] excitation_field_ch3,
    // Non-volatile memory port
    output logic nv_req,
    output logic nv_we,
    output logic [NV_ADDR_W-1:0] nv_addr,
    output logic [7:0] nv_wdata,
    input wire logic nv_done,
    input wire logic [7:0] nv_rdata
);

    typedef enum logic [3:0] {
        ST_OPCODE, ST_PARAM, ST_NV_WAIT, ST_SEND, ST_SKIP
    } bad_state_t;

    bad_state_t state;
    logic [7:0] opcode;
    logic [2:0] param_idx;
    logic [1:0] sel_chan;
    logic [31:0] setting_word;
    logic [4:0] send_idx;
    logic [4:0] send_len;
    logic [3:0][31:0] snap_word;
    logic [3:0][7:0] snap_num;
    logic [7:0] nv_data_hold;
    logic cmd_take;
    logic rsp_take;
    logic [2:0] need;
    logic [5:0] next_count;

    // Status word build: bits 31:30 low, sign, magnitude
    function automatic logic [31:0] pack_result(input bad_pkg::bad_result_t r);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[bad_pkg::SIGN_BIT] = r.sign_flag;
        w[bad_pkg::MAG_MSB:0] = r.magnitude;
        if (r.overrange) begin
            w[bad_pkg::SIGN_BIT] = 1'b1;
            w[bad_pkg::MAG_MSB] = 1'b1;
        end else if (r.underrange) begin
            w[bad_pkg::SIGN_BIT] = 1'b0;
            w[bad_pkg::MAG_MSB] = 1'b0;
        end
        return w;
    endfunction : pack_result

    // Parameter bytes per opcode; 7 means unknown
    function automatic logic [2:0] param_count(input logic [7:0] op);
        logic [2:0] n;
        n = 3'h7;
        if (op == bad_pkg::OP_PROGRAM_SETTING) begin
            n = 3'h5;
        end else if (op == bad_pkg::OP_READ_ALL) begin
            n = 3'h0;
        end else if (op == bad_pkg::OP_EXCITATION) begin
            n = 3'h1;
        end else if (op == bad_pkg::OP_NV_READ) begin
            n = 3'h1;
        end else if (op == bad_pkg::OP_NV_WRITE) begin
            n = 3'h2;
        end
        return n;
    endfunction : param_count

    // Oversample code to log2 ratio; 0 for unlisted codes
    function automatic logic [3:0] osr_log2(input logic [11:0] code);
        logic [3:0] l;
        l = 4'h0;
        if (code >= bad_pkg::OSR_CODE_FIRST && code <= bad_pkg::OSR_CODE_LAST_STEP) begin
            l = 4'(code - bad_pkg::OSR_CODE_FIRST) + bad_pkg::OSR_LOG2_BASE;
        end else if (code == bad_pkg::OSR_CODE_TOP) begin
            l = bad_pkg::OSR_LOG2_TOP;
        end
        return l;
    endfunction : osr_log2

    assign cmd_take = cmd_valid && cmd_ready;
    assign rsp_take = rsp_valid && rsp_ready;
    assign need = param_count(cmd_byte);
    assign cmd_ready = (state == ST_OPCODE) || (state == ST_PARAM) || (state == ST_SKIP && !cmd_first);
    assign rsp_valid = (state == ST_SEND);

    // Reply byte select
    always_comb begin
        rsp_byte = 8'h00;
        if (opcode == bad_pkg::OP_NV_READ) begin
            rsp_byte = nv_data_hold;
        // Result words channel order, LSB first
        end else if (send_idx < 5'h10) begin
            rsp_byte = snap_word[send_idx[3:2]][8*send_idx[1:0] +: 8];
        end else begin
            rsp_byte = snap_num[send_idx[1:0]];
        end
    end

    // Command sequencing
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_OPCODE;
            opcode <= 8'h00;
            param_idx <= 3'h0;
            send_idx <= 5'h00;
            send_len <= 5'h00;
            cmd_error <= 1'b0;
        end else begin
            cmd_error <= 1'b0;
            case (state)
                ST_OPCODE: begin
                    if (cmd_take) begin
                        opcode <= cmd_byte;
                        param_idx <= 3'h0;
                        send_idx <= 5'h00;
                        if (need == 3'h7) begin
                            cmd_error <= 1'b1;
                            state <= ST_SKIP;
                        end else if (need == 3'h0) begin
                            send_len <= 5'(bad_pkg::READ_ALL_BYTES);
                            state <= ST_SEND;
                        end else begin
                            state <= ST_PARAM;
                        end
                    end
                end
                ST_PARAM: begin
                    if (cmd_take) begin
                        param_idx <= param_idx + 3'h1;
                        if (param_idx + 3'h1 == param_count(opcode)) begin
                            if (opcode == bad_pkg::OP_NV_READ || opcode == bad_pkg::OP_NV_WRITE) begin
                                state <= ST_NV_WAIT;
                            end else begin
                                state <= ST_OPCODE;
                            end
                        end
                    end
                end
                ST_NV_WAIT: begin
                    if (nv_done) begin
                        if (opcode == bad_pkg::OP_NV_READ) begin
                            send_len <= 5'h01;
                            state <= ST_SEND;
                        end else begin
                            state <= ST_OPCODE;
                        end
                    end
                end
                ST_SEND: begin
                    if (rsp_take) begin
                        send_idx <= send_idx + 5'h01;
                        if (send_idx + 5'h01 == send_len) begin
                            state <= ST_OPCODE;
                        end
                    end
                end
                ST_SKIP: begin
                    // Unknown action: drop bytes, leave next opcode untaken
                    if (cmd_valid && cmd_first) begin
                        state <= ST_OPCODE;
                    end
                end
                default: state <= ST_OPCODE;
            endcase
        end
    end

    // Response length per packet
    always_comb begin
        next_count = rsp_count;
        if (cmd_take && cmd_first && state == ST_OPCODE) begin
            next_count = 6'h00;
        end
        if (rsp_take) begin
            next_count = next_count + 6'h01;
        end
    end

    // Flag reply bytes past packet limit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rsp_count <= 6'h00;
            rsp_overflow <= 1'b0;
        end else begin
            rsp_count <= next_count;
            if (cmd_take && cmd_first && state == ST_OPCODE) begin
                rsp_overflow <= 1'b0;
            end
            if (next_count > 6'(bad_pkg::RSP_MAX_BYTES)) begin
                rsp_overflow <= 1'b1;
            end
        end
    end

    // Result snapshot at the read-all opcode so the reply is coherent
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            snap_word <= '0;
            snap_num <= '0;
        end else if (state == ST_OPCODE && cmd_take && cmd_byte == bad_pkg::OP_READ_ALL) begin
            for (int i = 0; i < 4; i++) begin
                snap_word[i] <= pack_result(conv_result[i]);
                snap_num[i] <= sample_number[i];
            end
        end
    end

    // Channel select and setting word gather
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_chan <= 2'h0;
            setting_word <= 32'h0000_0000;
        end else if (state == ST_PARAM && cmd_take && opcode == bad_pkg::OP_PROGRAM_SETTING) begin
            if (param_idx == 3'h0) begin
                // Reserved upper six bits ignored
                sel_chan <= cmd_byte[1:0];
            end else begin
                setting_word[8*(param_idx - 3'h1) +: 8] <= cmd_byte;
            end
        end
    end

    // Channel settings store
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                channel_setting[i].osr_code <= bad_pkg::OSR_RESET_CODE;
                channel_setting[i].osr_log2 <= bad_pkg::OSR_LOG2_BASE;
                channel_setting[i].speed_mult <= 1'b0;
            end
            setting_strobe <= 4'h0;
        end else begin
            setting_strobe <= 4'h0;
            if (state == ST_PARAM && cmd_take && opcode == bad_pkg::OP_PROGRAM_SETTING && param_idx == 3'h4) begin
                // Ratio code from top twelve bits
                channel_setting[sel_chan].osr_code <= {cmd_byte, setting_word[23:20]};
                channel_setting[sel_chan].osr_log2 <= osr_log2({cmd_byte, setting_word[23:20]});
                channel_setting[sel_chan].speed_mult <= setting_word[bad_pkg::SPEED_BIT];
                setting_strobe[sel_chan] <= 1'b1;
            end
        end
    end

    // Excitation fields, held until next excitation command
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            excitation_field_ch0 <= bad_pkg::EXC_1V25;
            excitation_field_ch1 <= bad_pkg::EXC_1V25;
            excitation_field_ch2 <= bad_pkg::EXC_1V25;
            excitation_field_ch3 <= bad_pkg::EXC_1V25;
        end else if (state == ST_PARAM && cmd_take && opcode == bad_pkg::OP_EXCITATION) begin
            excitation_field_ch0 <= cmd_byte[1:0];
            excitation_field_ch1 <= cmd_byte[3:2];
            excitation_field_ch2 <= cmd_byte[5:4];
            excitation_field_ch3 <= cmd_byte[7:6];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nv_req <= 1'b0;
            nv_we <= 1'b0;
            nv_addr <= '0;
            nv_wdata <= 8'h00;
            nv_data_hold <= 8'h00;
        end else begin
            if (state == ST_PARAM && cmd_take) begin
                if (param_idx == 3'h0) begin
                    nv_addr <= NV_ADDR_W'(cmd_byte);
                end else begin
                    nv_wdata <= cmd_byte;
                end
                if (param_idx + 3'h1 == param_count(opcode) &&
                        (opcode == bad_pkg::OP_NV_READ || opcode == bad_pkg::OP_NV_WRITE)) begin
                    nv_req <= 1'b1;
                    nv_we <= (opcode == bad_pkg::OP_NV_WRITE);
                end
            end
            if (state == ST_NV_WAIT && nv_done) begin
                nv_req <= 1'b0;
                nv_we <= 1'b0;
                nv_data_hold <= nv_rdata;
            end
        end
    end

endmodule : bad_decoder

`default_nettype wire

/* src/bad_pkg.sv */
/*
 * Constants and carrier types for the bridge ADC action decoder.
 * Assumes a single module clock domain; no other files needed.
 */
package bad_pkg;
    localparam logic [7:0] OP_PROGRAM_SETTING = 8'h00;
    localparam logic [7:0] OP_READ_ALL = 8'h01;
    localparam logic [7:0] OP_EXCITATION = 8'h02;
    localparam logic [7:0] OP_NV_READ = 8'h0d;
    localparam logic [7:0] OP_NV_WRITE = 8'h0e;
    localparam int RSP_MAX_BYTES = 26;
    localparam int READ_ALL_BYTES = 20;
    localparam int OSR_LSB = 20;
    localparam int SPEED_BIT = 19;
    localparam logic [11:0] OSR_CODE_FIRST = 12'ha01;
    localparam logic [11:0] OSR_CODE_LAST_STEP = 12'ha09;
    localparam logic [11:0] OSR_CODE_TOP = 12'ha0f;
    localparam logic [3:0] OSR_LOG2_BASE = 4'h6;
    localparam logic [3:0] OSR_LOG2_TOP = 4'hf;
    localparam logic [1:0] EXC_1V25 = 2'h0;
    localparam logic [1:0] EXC_2V = 2'h1;
    localparam logic [1:0] EXC_3V = 2'h2;
    localparam logic [1:0] EXC_5V = 2'h3;
    localparam int SIGN_BIT = 29;
    localparam int MAG_MSB = 28;
    localparam logic [11:0] OSR_RESET_CODE = 12'ha01;

    typedef struct packed {
        logic [11:0] osr_code;
        logic [3:0] osr_log2;
        logic speed_mult;
    } bad_setting_t;

    typedef struct packed {
        logic overrange;
        logic underrange;
        logic sign_flag;
        logic [28:0] magnitude;
    } bad_result_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } bad_byte_t;
endpackage : bad_pkg
